// ---- rtl/rtcp_map.svh ----
// Register offsets, field positions and reset values of the counter block.
// Assumes a 4-bit word address and 16-bit data on the register port.
`ifndef RTCP_MAP_SVH
`define RTCP_MAP_SVH

// ---------------------------------------------------------------------
// Register word addresses
// ---------------------------------------------------------------------
`define RTCP_CTRL_ADR     4'h0
`define RTCP_IEN_ADR      4'h2
`define RTCP_FLAG_ADR     4'h3
`define RTCP_CNT_ADR      4'h4
`define RTCP_PER_ADR      4'h5
`define RTCP_CMP_ADR      4'h6
`define RTCP_PITCTRL_ADR  4'h7
`define RTCP_DBG_ADR      4'h8

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define RTCP_CTRL_EN_BIT  0
`define RTCP_CTRL_PS_LSB  1
`define RTCP_CTRL_CS_LSB  5
`define RTCP_OVF_BIT      0
`define RTCP_CMP_BIT      1
`define RTCP_PIT_BIT      2
`define RTCP_PIT_EN_BIT   0
`define RTCP_PIT_SEL_LSB  1
`define RTCP_DBG_RUN_BIT  0

// ---------------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------------
`define RTCP_PER_RST      16'hFFFF
`define RTCP_CMP_RST      16'h0000
`define RTCP_OSC_DIV      5'h1F
`define RTCP_PIT_EVT_TOP  12

`endif

// ---- rtl/rtcp_pkg.sv ----
// Types shared by the counter block modules.
// Assumes the constants of rtcp_map.svh for positions and values.
package rtcp_pkg;

  // Source clock selection codes.
  typedef enum logic [1:0] {
    RTCP_SRC_EXT,
    RTCP_SRC_OSC,
    RTCP_SRC_OSC32,
    RTCP_SRC_OFF
  } rtcp_src_t;

  // Register port request, one cycle per access.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  adr;
    logic [15:0] wdata;
  } rtcp_req_t;

  // Whole state of the main module.
  typedef struct packed {
    logic        rtc_en;
    logic [3:0]  presc_sel;
    rtcp_src_t   src_sel;
    logic [2:0]  ien;
    logic [2:0]  flag;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] cmp;
    logic        pit_en;
    logic [3:0]  pit_sel;
    logic        dbg_run;
    logic        ovf_evt;
    logic        cmp_evt;
    logic [7:0]  pit_evt;
    logic        pit_lvl;
    logic        irq_rtc;
    logic        irq_pit;
    logic [15:0] rdata;
  } rtcp_state_t;

endpackage : rtcp_pkg

// ---- rtl/rtcp_src_sel.sv ----
// Source clock selector: turns the chosen slow clock into tick pulses.
// Assumes both slow clocks are sampled levels, at most a quarter of mclk.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module rtcp_src_sel
  import rtcp_pkg::*;
(
  input  wire logic      mclk_i,     // Bus clock.
  input  wire logic      arst_n_i,   // Asynchronous reset, active low.
  input  wire logic      ext_clk_i,  // External slow clock level.
  input  wire logic      osc_clk_i,  // Low-power oscillator level.
  input  rtcp_src_t      src_sel_i,  // Chosen source.
  output logic           tick_o      // One pulse per source rising edge.
);

  // State: previous levels, divide-by-32 counter, tick.
  typedef struct packed {
    logic       ext_d;
    logic       osc_d;
    logic [4:0] div;
    logic       tick;
  } rtcp_sel_t;

  rtcp_sel_t st_ff;   // Registered state.
  rtcp_sel_t nxt_st;  // Next state.

  // ---------------------------------------------------------------------
  // Edge detection and selection
  // ---------------------------------------------------------------------
  // Rising edges of the chosen source make a one-cycle tick.
  always_comb
  begin
    logic osc_rise;
    osc_rise     = osc_clk_i & ~st_ff.osc_d;
    nxt_st       = st_ff;
    nxt_st.ext_d = ext_clk_i;
    nxt_st.osc_d = osc_clk_i;
    if (osc_rise)
    begin
      nxt_st.div = st_ff.div + 5'h1;
    end
    case (src_sel_i)
      RTCP_SRC_EXT:   nxt_st.tick = ext_clk_i & ~st_ff.ext_d;
      RTCP_SRC_OSC:   nxt_st.tick = osc_rise;
      RTCP_SRC_OSC32: nxt_st.tick = osc_rise && (st_ff.div == `RTCP_OSC_DIV);
      default:        nxt_st.tick = 1'b0;
    endcase
  end

  // Registers the state.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

  // Checks the divided source ticks once per 32 oscillator edges.
  // The divider has just wrapped, so it reads zero beside the tick.
  a_osc32_tick: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    st_ff.tick && $past(src_sel_i) == RTCP_SRC_OSC32
    |-> st_ff.div == 5'h0)
    else $error("divided tick off phase");

endmodule : rtcp_src_sel

// ---- rtl/rtcp_presc.sv ----
// Shared 15-bit prescaler counting source ticks.
// Assumes one-cycle tick pulses from the source selector.
`timescale 1ns/1ps
module rtcp_presc
  import rtcp_pkg::*;
#(
  parameter int WIDTH = 15  // Prescaler width.
)
(
  input  wire logic             mclk_i,    // Bus clock.
  input  wire logic             arst_n_i,  // Asynchronous reset, active low.
  input  wire logic             tick_i,    // Source tick.
  input  wire logic             enable_i,  // Either function enabled.
  input  wire logic             run_i,     // Not halted by debug.
  output logic [WIDTH-1:0]      cnt_o,     // Prescaler value.
  output logic                  step_o     // Value advanced last cycle.
);

  initial
  begin
    if (WIDTH < 13 || WIDTH > 15)
      $error("prescaler width unsupported");
  end

  // State: count and step marker.
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             step;
  } rtcp_pre_t;

  rtcp_pre_t st_ff;   // Registered state.
  rtcp_pre_t nxt_st;  // Next state.

  // ---------------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------------
  // Off means held at zero, so an enable always starts a fresh phase.
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.step = 1'b0;
    if (!enable_i)
    begin
      nxt_st.cnt = '0;
    end
    else if (tick_i && run_i)
    begin
      nxt_st.cnt  = st_ff.cnt + 1'b1;
      nxt_st.step = 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign cnt_o  = st_ff.cnt;
  assign step_o = st_ff.step;

  // Prescaler is zero one cycle after both functions are off.
  a_presc_off_zero: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    !enable_i |=> st_ff.cnt == '0)
    else $error("prescaler not cleared when off");

  // A halted prescaler never moves while enabled.
  a_presc_halt: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    enable_i && !run_i |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("prescaler moved while halted");

endmodule : rtcp_presc

// ---- rtl/rtcp_top.sv ----
// Real-time counter with periodic tick timer: registers, counter, flags.
// Assumes a single-cycle register port with read data one cycle later,
// and slow clocks at most a quarter of mclk.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module rtcp_top
  import rtcp_pkg::*;
#(
  parameter int PRESC_W = 15  // Prescaler width.
)
(
  input  wire logic        mclk_i,        // Bus clock, 125 MHz.
  input  wire logic        arst_n_i,      // Asynchronous reset, active low.
  input  wire logic        ext_clk_i,     // External slow clock.
  input  wire logic        osc_clk_i,     // Low-power oscillator.
  input  wire logic        dbg_halt_i,    // Processor halted by debugger.
  input  wire logic        wr_i,          // Write strobe.
  input  wire logic        rd_i,          // Read strobe.
  input  wire logic [3:0]  adr_i,         // Word address.
  input  wire logic [15:0] wdata_i,       // Write data.
  output logic      [15:0] rdata_o,       // Read data, cycle after strobe.
  output logic             irq_rtc_o,     // Overflow or compare request.
  output logic             irq_pit_o,     // Periodic tick request.
  output logic             ovf_evt_o,     // Overflow event strobe.
  output logic             cmp_evt_o,     // Compare event strobe.
  output logic      [7:0]  pit_evt_o      // Periodic tick event clocks.
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------
  // True when the prescaler just wrapped its low n bits (divide by 2^n).
  function automatic logic div_hit(input logic [PRESC_W-1:0] p,
                                   input logic [3:0]         n);
    logic [PRESC_W-1:0] mask;
    mask = PRESC_W'((16'h1 << n) - 16'h1);
    return (p & mask) == '0;
  endfunction : div_hit

  // Prescaler bit whose period is the selected tick period.
  function automatic logic pit_bit(input logic [PRESC_W-1:0] p,
                                   input logic [3:0]         s);
    logic b;
    b = 1'b0;
    if (s != 4'h0 && 32'(s) < PRESC_W)
    begin
      b = p[s];
    end
    return b;
  endfunction : pit_bit

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  rtcp_state_t       st_ff;     // Registered state.
  rtcp_state_t       nxt_st;    // Next state.
  rtcp_req_t         req;       // Bundled register access.
  logic              src_tick;  // Selected source tick.
  logic              run;       // Not stopped by debug halt.
  logic [PRESC_W-1:0] presc;    // Prescaler value.
  logic              step;      // Prescaler advanced.
  logic              cnt_tick;  // Counter advances this cycle.
  logic              pit_now;   // Selected tick level.

  assign req = '{wr: wr_i, rd: rd_i, adr: adr_i, wdata: wdata_i};

  assign run = !dbg_halt_i || st_ff.dbg_run;

  // ---------------------------------------------------------------------
  // Source and prescaler
  // ---------------------------------------------------------------------
  // one source for both functions
  rtcp_src_sel u_src (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .ext_clk_i (ext_clk_i),
    .osc_clk_i (osc_clk_i),
    .src_sel_i (st_ff.src_sel),
    .tick_o    (src_tick)
  );

  rtcp_presc #(.WIDTH(PRESC_W)) u_presc (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (src_tick),
    .enable_i (st_ff.rtc_en || st_ff.pit_en),
    .run_i    (run),
    .cnt_o    (presc),
    .step_o   (step)
  );

  // divided count tick, none while halted
  // A step registered just before a halt must not move the counter.
  assign cnt_tick = step && run && st_ff.rtc_en
                    && div_hit(presc, st_ff.presc_sel);
  assign pit_now  = st_ff.pit_en && pit_bit(presc, st_ff.pit_sel);

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // Counter, events, flags and the register port in one process.
  always_comb
  begin
    logic [2:0] set;
    logic [2:0] clr;
    set    = 3'h0;
    clr    = 3'h0;
    nxt_st = st_ff;

    // strobes end at the next source step, or in the next cycle while the counter is off.
    if (step || !st_ff.rtc_en)
    begin
      nxt_st.ovf_evt = 1'b0;
      nxt_st.cmp_evt = 1'b0;
    end

    if (cnt_tick)
    begin
      if (st_ff.cnt == st_ff.per)
      begin
        nxt_st.cnt           = 16'h0000;
        nxt_st.ovf_evt       = 1'b1;
        set[`RTCP_OVF_BIT]   = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
      if (st_ff.cnt == st_ff.cmp)
      begin
        nxt_st.cmp_evt       = 1'b1;
        set[`RTCP_CMP_BIT]   = 1'b1;
      end
    end

    // tick level and its rising edge
    nxt_st.pit_lvl = pit_now;
    if (pit_now && !st_ff.pit_lvl)
    begin
      set[`RTCP_PIT_BIT] = 1'b1;
    end

    for (int i = 0; i < 8; i++)
    begin
      nxt_st.pit_evt[i] = st_ff.pit_en && presc[`RTCP_PIT_EVT_TOP - i];
    end

    // Register writes; a counter write beats the internal update.
    if (req.wr)
    begin
      case (req.adr)
        `RTCP_CTRL_ADR:
        begin
          nxt_st.rtc_en    = req.wdata[`RTCP_CTRL_EN_BIT];
          nxt_st.presc_sel = req.wdata[`RTCP_CTRL_PS_LSB +: 4];
          nxt_st.src_sel   = rtcp_src_t'(req.wdata[`RTCP_CTRL_CS_LSB +: 2]);
        end
        `RTCP_IEN_ADR:     nxt_st.ien = req.wdata[2:0];
        `RTCP_FLAG_ADR:    clr        = req.wdata[2:0];
        `RTCP_CNT_ADR:     nxt_st.cnt = req.wdata;
        `RTCP_PER_ADR:     nxt_st.per = req.wdata;
        `RTCP_CMP_ADR:     nxt_st.cmp = req.wdata;
        `RTCP_PITCTRL_ADR:
        begin
          nxt_st.pit_en  = req.wdata[`RTCP_PIT_EN_BIT];
          nxt_st.pit_sel = req.wdata[`RTCP_PIT_SEL_LSB +: 4];
        end
        `RTCP_DBG_ADR:     nxt_st.dbg_run = req.wdata[`RTCP_DBG_RUN_BIT];
        default:           nxt_st.dbg_run = st_ff.dbg_run;
      endcase
    end

    nxt_st.flag = (st_ff.flag & ~clr) | set;

    nxt_st.irq_rtc = |(nxt_st.flag[1:0] & nxt_st.ien[1:0]);
    nxt_st.irq_pit = nxt_st.flag[`RTCP_PIT_BIT] & nxt_st.ien[`RTCP_PIT_BIT];

    // Read data stand only in the cycle after the read strobe.
    nxt_st.rdata = 16'h0000;
    if (req.rd)
    begin
      case (req.adr)
        `RTCP_CTRL_ADR:
          nxt_st.rdata = {9'h000, st_ff.src_sel, st_ff.presc_sel,
                          st_ff.rtc_en};
        `RTCP_IEN_ADR:     nxt_st.rdata = {13'h0000, st_ff.ien};
        `RTCP_FLAG_ADR:    nxt_st.rdata = {13'h0000, st_ff.flag};
        `RTCP_CNT_ADR:     nxt_st.rdata = st_ff.cnt;
        `RTCP_PER_ADR:     nxt_st.rdata = st_ff.per;
        `RTCP_CMP_ADR:     nxt_st.rdata = st_ff.cmp;
        `RTCP_PITCTRL_ADR:
          nxt_st.rdata = {11'h000, st_ff.pit_sel, st_ff.pit_en};
        `RTCP_DBG_ADR:     nxt_st.rdata = {15'h0000, st_ff.dbg_run};
        default:           nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Reset gives a stopped block with the period at its top value.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_ff     <= '0;
      st_ff.per <= `RTCP_PER_RST;
      st_ff.cmp <= `RTCP_CMP_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_o   = st_ff.rdata;
  assign irq_rtc_o = st_ff.irq_rtc;
  assign irq_pit_o = st_ff.irq_pit;
  assign ovf_evt_o = st_ff.ovf_evt;
  assign cmp_evt_o = st_ff.cmp_evt;
  assign pit_evt_o = st_ff.pit_evt;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  // wrap to zero
  a_cnt_wrap: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    cnt_tick && st_ff.cnt == st_ff.per && !(wr_i && adr_i == `RTCP_CNT_ADR)
    |=> st_ff.cnt == 16'h0000 && ovf_evt_o)
    else $error("counter did not wrap at period");

  a_cnt_step: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    cnt_tick && st_ff.cnt != st_ff.per && !(wr_i && adr_i == `RTCP_CNT_ADR)
    |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
    else $error("counter did not advance");

  a_cmp_event: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    cnt_tick && st_ff.cnt == st_ff.cmp
    |=> cmp_evt_o && st_ff.flag[`RTCP_CMP_BIT])
    else $error("compare match missed");

  a_ovf_cause: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    $rose(ovf_evt_o) |-> $past(cnt_tick)
    && $past(st_ff.cnt) == $past(st_ff.per))
    else $error("overflow without period match");

  a_evt_hold: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    ovf_evt_o && !step && st_ff.rtc_en |=> ovf_evt_o)
    else $error("overflow strobe shorter than a source cycle");

  a_flag_sticky: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    st_ff.flag[`RTCP_OVF_BIT]
    && !(wr_i && adr_i == `RTCP_FLAG_ADR && wdata_i[`RTCP_OVF_BIT])
    |=> st_ff.flag[`RTCP_OVF_BIT])
    else $error("overflow flag lost without clear");

  a_pit_flag: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    $rose(st_ff.pit_lvl) |-> st_ff.flag[`RTCP_PIT_BIT])
    else $error("tick edge did not set flag");

  a_halt_hold: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    dbg_halt_i && !st_ff.dbg_run && !wr_i
    |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("counter moved while halted");

  a_read_data: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rd_i && adr_i == `RTCP_PER_ADR |=> rdata_o == $past(st_ff.per))
    else $error("period read back wrong");

endmodule : rtcp_top

// ---- verif/tb_rtcp_top.sv ----
// Self-checking bench for the counter block with periodic tick timer.
// Assumes rtcp_top and the register map of rtcp_map.svh.
`timescale 1ns/1ps
`include "rtcp_map.svh"
module tb_rtcp_top
  import rtcp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i;       // Bus clock.
  logic        arst_n_i;     // Reset, active low.
  logic        ext_clk_i;    // External slow clock.
  logic        osc_clk_i;    // Oscillator slow clock.
  logic        dbg_halt_i;   // Debugger halt.
  logic        wr_i;         // Write strobe.
  logic        rd_i;         // Read strobe.
  logic [3:0]  adr_i;        // Word address.
  logic [15:0] wdata_i;      // Write data.
  logic [15:0] rdata_o;      // Read data.
  logic        irq_rtc_o;    // Counter request.
  logic        irq_pit_o;    // Tick request.
  logic        ovf_evt_o;    // Overflow strobe.
  logic        cmp_evt_o;    // Compare strobe.
  logic [7:0]  pit_evt_o;    // Tick event clocks.
  logic [1:0]  div_ff;       // Slow clock phase.
  int          osc_rises;    // Oscillator rising edges so far.
  int          ext_rises;    // External rising edges so far.
  int          cycles;       // Watchdog count.
  int          mismatches;   // Failed comparisons.
  int          comparisons;  // All comparisons.
  logic        use_ext;      // Edges counted on the external clock.
  int unsigned seed;         // Seeding result.

  rtcp_top u_dut (
    .mclk_i     (mclk_i),
    .arst_n_i   (arst_n_i),
    .ext_clk_i  (ext_clk_i),
    .osc_clk_i  (osc_clk_i),
    .dbg_halt_i (dbg_halt_i),
    .wr_i       (wr_i),
    .rd_i       (rd_i),
    .adr_i      (adr_i),
    .wdata_i    (wdata_i),
    .rdata_o    (rdata_o),
    .irq_rtc_o  (irq_rtc_o),
    .irq_pit_o  (irq_pit_o),
    .ovf_evt_o  (ovf_evt_o),
    .cmp_evt_o  (cmp_evt_o),
    .pit_evt_o  (pit_evt_o)
  );

  // ----------------------------------------------------------------
  // Clocks and watchdog
  // ----------------------------------------------------------------
  // Bus clock of 8 ns.
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // Slow clocks of eight bus cycles, a quarter period apart.
  // source slow enough
  always @(posedge mclk_i)
  begin
    div_ff <= div_ff + 2'h1;
    if (div_ff == 2'h3)
    begin
      osc_clk_i <= ~osc_clk_i;
      if (!osc_clk_i)
        osc_rises <= osc_rises + 1;
    end
    if (div_ff == 2'h1)
    begin
      ext_clk_i <= ~ext_clk_i;
      if (!ext_clk_i)
        ext_rises <= ext_rises + 1;
    end
  end

  // Cuts a hang short.
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compares one value and counts it.
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task summarize;
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // One register write cycle.
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    adr_i   <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // One register read cycle; data taken in the following cycle.
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_i  <= 1'b1;
    adr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // Selects a watched output: 0 ovf, 1 cmp, 2 tick irq, 3+i event i.
  function automatic logic sig(input int k);
    if (k == 0)
      return ovf_evt_o;
    if (k == 1)
      return cmp_evt_o;
    if (k == 2)
      return irq_pit_o;
    return pit_evt_o[k-3];
  endfunction : sig

  // Moves to just after the next edge.
  task step;
    @(posedge mclk_i);
    #1;
  endtask : step

  // Waits for a rise and returns the source edge count.
  task rise(input int k, output int e);
    while (sig(k) === 1'b1)
      step();
    while (sig(k) !== 1'b1)
      step();
    e = use_ext ? ext_rises : osc_rises;
  endtask : rise

  // Waits for a fall and returns the source edge count.
  task fall(input int k, output int e);
    while (sig(k) !== 1'b0)
      step();
    e = use_ext ? ext_rises : osc_rises;
  endtask : fall

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    logic [15:0] a;
    int          e0;
    int          e1;
    int          per;
    int          cv;
    int          dv;
    int          w;
    {arst_n_i, ext_clk_i, osc_clk_i, dbg_halt_i, wr_i, rd_i} = 6'h00;
    adr_i = 4'h0;
    wdata_i = 16'h0000;
    div_ff = 2'h0;
    {osc_rises, ext_rises, cycles, mismatches, comparisons} = '0;
    use_ext = 1'b0;
    seed = $urandom(12151);
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    // Reset values, unmapped words read zero.
    wr(4'h1, 16'hFFFF);
    for (int i = 0; i < 16; i++)
    begin
      rd(4'(i), v);
      chk("reset", (i == `RTCP_PER_ADR) ? 16'hFFFF : 16'h0000, v);
    end
    chk("outputs", 16'h0000, {4'h0, irq_rtc_o, irq_pit_o, ovf_evt_o,
        cmp_evt_o, pit_evt_o});
    v = 16'($urandom);
    wr(`RTCP_CMP_ADR, v);
    rd(`RTCP_CMP_ADR, a);
    chk("cmp_rw", v, a);
    wr(`RTCP_IEN_ADR, 16'h0003);
    for (int t = 0; t < 3; t++)
    begin
      use_ext = (t == 0);
      dv = ((t == 1) ? 4 : 1) * ((t == 2) ? 32 : 1);
      per = 3 + ($urandom % 4);
      cv = $urandom % per;
      wr(`RTCP_PER_ADR, 16'(per));
      wr(`RTCP_CMP_ADR, 16'(cv));
      wr(`RTCP_CNT_ADR, 16'h0000);
      wr(`RTCP_CTRL_ADR, 16'(1 | (((t == 1) ? 2 : 0) << 1) | (t << 5)));
      rise(1, e0);
      rise(0, e1);
      chk("cmp_to_ovf", 16'((per - cv) * dv), 16'(e1 - e0));
      w = 0;
      while (sig(0) === 1'b1)
      begin
        step();
        w++;
      end
      chk("ovf_width", 16'((t == 2) ? 256 : 8), 16'(w));
      rise(0, e0);
      chk("ovf_period", 16'((per + 1) * dv), 16'(e0 - e1));
      rd(`RTCP_CNT_ADR, v);
      chk("cnt_in_range", 16'h0001, 16'(v <= per));
      wr(`RTCP_CTRL_ADR, 16'h0000);
    end
    // flags held, masked, cleared by one
    rd(`RTCP_FLAG_ADR, v);
    chk("flags", 16'h0003, v);
    chk("irq_rtc", 16'h0001, 16'(irq_rtc_o));
    wr(`RTCP_IEN_ADR, 16'h0000);
    repeat (2) step();
    chk("irq_masked", 16'h0000, 16'(irq_rtc_o));
    wr(`RTCP_IEN_ADR, 16'h0003);
    wr(`RTCP_FLAG_ADR, 16'h0001);
    rd(`RTCP_FLAG_ADR, v);
    chk("flags_ovf_clr", 16'h0002, v);
    wr(`RTCP_FLAG_ADR, 16'h0002);
    rd(`RTCP_FLAG_ADR, v);
    chk("flags_clr", 16'h0000, v);
    chk("irq_clr", 16'h0000, 16'(irq_rtc_o));
    use_ext = 1'b0;
    wr(`RTCP_PER_ADR, 16'hFFFF);
    wr(`RTCP_CNT_ADR, 16'h0000);
    wr(`RTCP_CTRL_ADR, 16'h0021);
    repeat (100) step();
    @(posedge mclk_i);
    dbg_halt_i <= 1'b1;
    repeat (20) step();
    rd(`RTCP_CNT_ADR, a);
    repeat (200) step();
    rd(`RTCP_CNT_ADR, v);
    chk("halted_cnt", a, v);
    wr(`RTCP_DBG_ADR, 16'h0001);
    repeat (100) step();
    rd(`RTCP_CNT_ADR, v);
    chk("run_halted", 16'h0001, 16'(v !== a));
    @(posedge mclk_i);
    dbg_halt_i <= 1'b0;
    wr(`RTCP_DBG_ADR, 16'h0000);
    wr(`RTCP_CTRL_ADR, 16'h0000);
    // tick timer alone, starts from zero
    // The last control write left the external clock as the source.
    use_ext = 1'b1;
    wr(`RTCP_PITCTRL_ADR, 16'h0001);
    e0 = ext_rises;
    rise(10, e1);
    chk("pit_first", 16'h0001, 16'((e1 - e0) >= 31 && (e1 - e0) <= 33));
    // event clocks of 50 percent duty
    for (int i = 7; i > 3; i--)
    begin
      rise(3 + i, e0);
      fall(3 + i, e1);
      chk("pit_half", 16'(1 << (12 - i)), 16'(e1 - e0));
    end
    // tick request period for selections 1 to 3
    wr(`RTCP_IEN_ADR, 16'h0004);
    for (int s = 1; s < 4; s++)
    begin
      wr(`RTCP_PITCTRL_ADR, 16'(1 | (s << 1)));
      wr(`RTCP_FLAG_ADR, 16'h0004);
      rise(2, e0);
      wr(`RTCP_FLAG_ADR, 16'h0004);
      rise(2, e1);
      chk("pit_period", 16'(1 << (s + 1)), 16'(e1 - e0));
    end
    wr(`RTCP_PITCTRL_ADR, 16'h0001);
    wr(`RTCP_FLAG_ADR, 16'h0004);
    repeat (300) step();
    chk("pit_sel_none", 16'h0000, 16'(irq_pit_o));
    wr(`RTCP_PITCTRL_ADR, 16'h0000);
    repeat (4) step();
    chk("pit_off", 16'h0000, 16'(pit_evt_o));
    summarize();
  end
endmodule : tb_rtcp_top
